// *** hw/ivlw_pkg.sv ***
// Constants, types and helpers of the interrupt vectoring and long write block
package ivlw_pkg;
  // ----------------------------------------------------------------
  // Source counts and indices
  // ----------------------------------------------------------------
  localparam int N_SRC = 18;
  localparam int N_CORE = 3;
  localparam int N_PERIPH = 15;
  localparam int SRC_EXT = 0;
  localparam int SRC_T0OV = 1;
  localparam int SRC_T0CK = 2;
  localparam int SRC_PER = 3;
  localparam int PRA_W = 8;
  localparam int PRB_W = 7;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CORE_STATUS = 12'h000;
  localparam logic [11:0] OFF_CORE_IRQ_STATUS = 12'h004;
  localparam logic [11:0] OFF_PERIPH_REQ_A = 12'h008;
  localparam logic [11:0] OFF_PERIPH_EN_A = 12'h00C;
  localparam logic [11:0] OFF_PERIPH_REQ_B = 12'h010;
  localparam logic [11:0] OFF_PERIPH_EN_B = 12'h014;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CS_GID_BIT = 0;
  localparam int CS_LONG_BIT = 1;
  localparam int CIS_EN_LSB = 0;
  localparam int CIS_PEIE_BIT = 3;
  localparam int CIS_FLAG_LSB = 4;
  localparam int CIS_PEND_BIT = 7;
  localparam logic GID_RST = 1'b1;
  // ----------------------------------------------------------------
  // Vector addresses
  // ----------------------------------------------------------------
  localparam logic [15:0] VEC_EXT = 16'h0008;
  localparam logic [15:0] VEC_T0OV = 16'h0010;
  localparam logic [15:0] VEC_T0CK = 16'h0018;
  localparam logic [15:0] VEC_PER = 16'h0020;

  typedef enum logic {ST_RUN = 1'b0, ST_LONG = 1'b1} ivlw_state_t;

  // One-hot winner to its vector address
  function automatic logic [15:0] vec_addr_of(input logic [3:0] sel);
    logic [15:0] a;
    a = VEC_PER;
    if (sel[SRC_EXT]) a = VEC_EXT;
    else if (sel[SRC_T0OV]) a = VEC_T0OV;
    else if (sel[SRC_T0CK]) a = VEC_T0CK;
    return a;
  endfunction : vec_addr_of
endpackage : ivlw_pkg

// *** hw/ivlw_flag_if.sv ***
// Carrier between the controller and a bank of interrupt flags
`timescale 1ns/1ps
interface ivlw_flag_if #(parameter int W = 8) (input wire logic clk);
  logic [W-1:0] flags;
  logic [W-1:0] set;
  logic [W-1:0] hw_clr;
  logic sw_wr;
  logic [W-1:0] sw_data;
  modport bank (input clk, input set, input hw_clr, input sw_wr, input sw_data, output flags);
  modport ctl (output set, output hw_clr, output sw_wr, output sw_data, input flags);
endinterface : ivlw_flag_if

// *** hw/ivlw_flag_bank.sv ***
// Bank of sticky interrupt flags; hardware set beats any clear
`timescale 1ns/1ps
module ivlw_flag_bank #(
  parameter int W = 8
) (
  input wire logic rst_n,   // Synchronous reset, active low
  ivlw_flag_if.bank fi      // Set, clear and software write
);
  logic [W-1:0] flags_r;
  logic [W-1:0] flags_nxt;

  always_comb begin
    flags_nxt = ((fi.sw_wr ? fi.sw_data : flags_r) & ~fi.hw_clr) | fi.set;
  end

  always_ff @(posedge fi.clk) begin
    if (!rst_n) begin
      flags_r <= '0;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign fi.flags = flags_r;

  chk_set_not_lost: assert property (@(posedge fi.clk) disable iff (!rst_n)
    (flags_r & $past(fi.set)) == $past(fi.set))
    else $error("flag event lost");
endmodule : ivlw_flag_bank

// *** hw/ivlw_prio.sv ***
// Fixed priority pick among the three core sources and the peripheral group
`timescale 1ns/1ps
module ivlw_prio (
  input wire logic [2:0] core_pend,   // Enabled and flagged core sources
  input wire logic periph_pend,       // Any enabled peripheral request
  output logic [3:0] sel,             // One-hot winner
  output logic any                    // Some source pending
);
  always_comb begin
    sel = 4'h0;
    if (core_pend[ivlw_pkg::SRC_EXT]) begin
      sel[ivlw_pkg::SRC_EXT] = 1'b1;
    end else if (core_pend[ivlw_pkg::SRC_T0OV]) begin
      sel[ivlw_pkg::SRC_T0OV] = 1'b1;
    end else if (core_pend[ivlw_pkg::SRC_T0CK]) begin
      sel[ivlw_pkg::SRC_T0CK] = 1'b1;
    end else if (periph_pend) begin
      sel[ivlw_pkg::SRC_PER] = 1'b1;
    end
    any = |sel;
  end
endmodule : ivlw_prio

// *** hw/ivlw_top.sv ***
// Interrupt vectoring and long table write control with APB registers
//
// What this block does
// - Eighteen sources: pin, timer0 overflow, timer0 pin edge, fifteen peripheral events.
// - While the global disable bit is set, no source vectors.
// - Taking an interrupt sets global disable, pushes return, loads the vector.
// - Four vectors: pin, timer0 overflow, timer0 pin edge, one shared peripheral.
// - Vectoring to a core source vector clears that source's flag.
// - Vectoring to the peripheral vector leaves peripheral flags untouched.
// - Each flag sets on its event regardless of enables and global disable.
// - Vectoring outside a long write waits for an instruction end, so two-cycle instructions add latency.
// - Return from interrupt pops the stack and clears global disable.
// - A table write starts a long write that halts execution until ended.
// - Only reset or an enabled flagged source ends a long write.
// - A core source ending a long write has the flag of the top-priority pending core source cleared, the pin first.
// - A table write with an enabled request pending aborts as a no-op.
// - A peripheral source ending a long write keeps its flag set.
// - After an interrupt ends a long write, vector only if global disable clear.
// - Without programming voltage a table write is a short write, memory unchanged.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module ivlw_top (
  input wire logic core_clk,                    // Core clock, 125 MHz
  input wire logic rst_n,                       // Synchronous reset, active low
  input wire logic psel,                        // APB select
  input wire logic penable,                     // APB enable
  input wire logic pwrite,                      // APB write
  input wire logic [11:0] paddr,                // APB byte address
  input wire logic [31:0] pwdata,               // APB write data
  output logic [31:0] prdata,                   // APB read data
  output logic pready,                          // APB ready
  output logic pslverr,                         // APB error, unmapped address
  input wire logic external_irq_pin,            // Pin, asynchronous
  input wire logic program_voltage_pin,         // Programming voltage present, asynchronous
  input wire logic timer0_overflow,             // Timer0 overflow pulse
  input wire logic timer0_clock_pin_edge,       // Timer0 pin edge pulse
  input wire logic [14:0] periph_evt,           // Peripheral event pulses
  input wire logic instr_end,                   // Pulse at end of each instruction
  input wire logic return_from_irq_instr,       // Pulse, return instruction executes
  input wire logic table_write_instr,           // Pulse, table write executes
  output logic vec_take,                        // Pulse: push return, load vector
  output logic [15:0] vec_addr,                 // Vector address, valid with vec_take
  output logic stack_pop,                       // Pulse: pop stack into counter
  output logic exec_halt,                       // Level: long write in progress
  output logic long_end,                        // Pulse: long write ended by interrupt
  output logic tbl_abort,                       // Pulse: table write replaced by no-op
  output logic tbl_short                        // Pulse: short write, memory unchanged
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic ext_s1_r, ext_s2_r, ext_s3_r;
  logic vpp_s1_r, vpp_s2_r;
  logic ext_rise;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ext_s1_r <= 1'b0;
      ext_s2_r <= 1'b0;
      ext_s3_r <= 1'b0;
      vpp_s1_r <= 1'b0;
      vpp_s2_r <= 1'b0;
    end else begin
      ext_s1_r <= external_irq_pin;
      ext_s2_r <= ext_s1_r;
      ext_s3_r <= ext_s2_r;
      vpp_s1_r <= program_voltage_pin;
      vpp_s2_r <= vpp_s1_r;
    end
  end

  assign ext_rise = ext_s2_r & ~ext_s3_r;

  // ----------------------------------------------------------------
  // Flag banks
  // ----------------------------------------------------------------
  ivlw_flag_if #(.W(ivlw_pkg::N_CORE)) core_if (.clk(core_clk));
  ivlw_flag_if #(.W(ivlw_pkg::N_PERIPH)) per_if (.clk(core_clk));

  ivlw_flag_bank #(.W(ivlw_pkg::N_CORE)) u_core_bank (.rst_n(rst_n), .fi(core_if));
  ivlw_flag_bank #(.W(ivlw_pkg::N_PERIPH)) u_per_bank (.rst_n(rst_n), .fi(per_if));

  logic [2:0] core_en_r, core_en_nxt;
  logic peie_r, peie_nxt;
  logic [14:0] per_en_r, per_en_nxt;
  logic gid_r, gid_nxt;
  logic [2:0] hw_clr_core;
  logic gid_set;

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic acc;
  logic wr_cs, wr_cis, wr_pra, wr_pea, wr_prb, wr_peb;
  logic mapped;

  assign acc = psel & penable & pready_r & pwrite;
  assign wr_cs = acc & (paddr == ivlw_pkg::OFF_CORE_STATUS);
  assign wr_cis = acc & (paddr == ivlw_pkg::OFF_CORE_IRQ_STATUS);
  assign wr_pra = acc & (paddr == ivlw_pkg::OFF_PERIPH_REQ_A);
  assign wr_pea = acc & (paddr == ivlw_pkg::OFF_PERIPH_EN_A);
  assign wr_prb = acc & (paddr == ivlw_pkg::OFF_PERIPH_REQ_B);
  assign wr_peb = acc & (paddr == ivlw_pkg::OFF_PERIPH_EN_B);

  logic [2:0] core_pend;
  logic [14:0] per_pend_vec;
  logic per_pend;
  logic [3:0] win_sel;
  logic win_any;
  ivlw_pkg::ivlw_state_t state_r, state_nxt;

  assign core_pend = core_if.flags & core_en_r;
  assign per_pend_vec = per_if.flags & per_en_r;
  assign per_pend = peie_r & (|per_pend_vec);

  always_comb begin
    pready_nxt = psel & ~penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h0000_0000;
    mapped = 1'b1;
    if (psel & ~penable) begin
      unique case (paddr)
        ivlw_pkg::OFF_CORE_STATUS: begin
          prdata_nxt[ivlw_pkg::CS_GID_BIT] = gid_r;
          prdata_nxt[ivlw_pkg::CS_LONG_BIT] = (state_r == ivlw_pkg::ST_LONG);
        end
        ivlw_pkg::OFF_CORE_IRQ_STATUS: begin
          prdata_nxt[ivlw_pkg::CIS_EN_LSB +: 3] = core_en_r;
          prdata_nxt[ivlw_pkg::CIS_PEIE_BIT] = peie_r;
          prdata_nxt[ivlw_pkg::CIS_FLAG_LSB +: 3] = core_if.flags;
          prdata_nxt[ivlw_pkg::CIS_PEND_BIT] = per_pend;
        end
        ivlw_pkg::OFF_PERIPH_REQ_A: prdata_nxt[7:0] = per_if.flags[7:0];
        ivlw_pkg::OFF_PERIPH_EN_A: prdata_nxt[7:0] = per_en_r[7:0];
        ivlw_pkg::OFF_PERIPH_REQ_B: prdata_nxt[6:0] = per_if.flags[14:8];
        ivlw_pkg::OFF_PERIPH_EN_B: prdata_nxt[6:0] = per_en_r[14:8];
        default: mapped = 1'b0;
      endcase
      pslverr_nxt = ~mapped;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
    end else begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Enables and flag writes
  // ----------------------------------------------------------------
  always_comb begin
    core_en_nxt = wr_cis ? pwdata[ivlw_pkg::CIS_EN_LSB +: 3] : core_en_r;
    peie_nxt = wr_cis ? pwdata[ivlw_pkg::CIS_PEIE_BIT] : peie_r;
    per_en_nxt = per_en_r;
    if (wr_pea) per_en_nxt[7:0] = pwdata[7:0];
    if (wr_peb) per_en_nxt[14:8] = pwdata[6:0];
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      core_en_r <= 3'h0;
      peie_r <= 1'b0;
      per_en_r <= 15'h0000;
    end else begin
      core_en_r <= core_en_nxt;
      peie_r <= peie_nxt;
      per_en_r <= per_en_nxt;
    end
  end

  assign core_if.set = {timer0_clock_pin_edge, timer0_overflow, ext_rise};
  assign core_if.sw_wr = wr_cis;
  assign core_if.sw_data = pwdata[ivlw_pkg::CIS_FLAG_LSB +: 3];
  assign core_if.hw_clr = hw_clr_core;
  assign per_if.set = periph_evt;
  assign per_if.sw_wr = wr_pra | wr_prb;
  assign per_if.sw_data = wr_pra ? {per_if.flags[14:8], pwdata[7:0]}
                                 : {pwdata[6:0], per_if.flags[7:0]};
  // Peripheral flags get no hardware clear at all
  assign per_if.hw_clr = 15'h0000;

  // ----------------------------------------------------------------
  // Vectoring and long write control
  // ----------------------------------------------------------------
  ivlw_prio u_prio (
    .core_pend(core_pend),
    .periph_pend(per_pend),
    .sel(win_sel),
    .any(win_any)
  );

  logic vec_r, vec_nxt;
  logic [15:0] vaddr_r, vaddr_nxt;
  logic pop_r, pop_nxt;
  logic halt_r, halt_nxt;
  logic end_r, end_nxt;
  logic abort_r, abort_nxt;
  logic short_r, short_nxt;

  always_comb begin
    state_nxt = state_r;
    vec_nxt = 1'b0;
    vaddr_nxt = vaddr_r;
    end_nxt = 1'b0;
    abort_nxt = 1'b0;
    short_nxt = 1'b0;
    hw_clr_core = 3'h0;
    gid_set = 1'b0;
    pop_nxt = return_from_irq_instr;
    unique case (state_r)
      ivlw_pkg::ST_RUN: begin
        if (table_write_instr) begin
          if (win_any) begin
            abort_nxt = 1'b1;
            hw_clr_core = win_sel[2:0];
          end else if (vpp_s2_r) begin
            state_nxt = ivlw_pkg::ST_LONG;
          end else begin
            short_nxt = 1'b1;
          end
        // Only at an instruction end, so a two-cycle one delays it a cycle
        end else if (instr_end && win_any && !gid_r) begin
          vec_nxt = 1'b1;
          vaddr_nxt = ivlw_pkg::vec_addr_of(win_sel);
          gid_set = 1'b1;
          hw_clr_core = win_sel[2:0];
        end
      end
      ivlw_pkg::ST_LONG: begin
        // Enable and flag end the write; global disable only gates the branch
        if (win_any) begin
          state_nxt = ivlw_pkg::ST_RUN;
          end_nxt = 1'b1;
          hw_clr_core = win_sel[2:0];
          if (!gid_r) begin
            vec_nxt = 1'b1;
            vaddr_nxt = ivlw_pkg::vec_addr_of(win_sel);
            gid_set = 1'b1;
          end
        end
      end
    endcase
    halt_nxt = (state_nxt == ivlw_pkg::ST_LONG);
    gid_nxt = wr_cs ? pwdata[ivlw_pkg::CS_GID_BIT] : gid_r;
    if (return_from_irq_instr) gid_nxt = 1'b0;
    if (gid_set) gid_nxt = 1'b1;
  end

  // Reset also ends a pending long write
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_r <= ivlw_pkg::ST_RUN;
      gid_r <= ivlw_pkg::GID_RST;
      vec_r <= 1'b0;
      vaddr_r <= 16'h0000;
      pop_r <= 1'b0;
      halt_r <= 1'b0;
      end_r <= 1'b0;
      abort_r <= 1'b0;
      short_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      gid_r <= gid_nxt;
      vec_r <= vec_nxt;
      vaddr_r <= vaddr_nxt;
      pop_r <= pop_nxt;
      halt_r <= halt_nxt;
      end_r <= end_nxt;
      abort_r <= abort_nxt;
      short_r <= short_nxt;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign vec_take = vec_r;
  assign vec_addr = vaddr_r;
  assign stack_pop = pop_r;
  assign exec_halt = halt_r;
  assign long_end = end_r;
  assign tbl_abort = abort_r;
  assign tbl_short = short_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence s_long_start;
    (state_r == ivlw_pkg::ST_RUN) && table_write_instr && !win_any && vpp_s2_r;
  endsequence
  sequence s_long_end;
    halt_r && win_any;
  endsequence

  chk_vec_sets_gid: assert property (vec_r |-> gid_r)
    else $error("vector without global disable");
  chk_gid_blocks: assert property (gid_r |=> !vec_r)
    else $error("vectored while globally disabled");
  chk_core_flag_clr: assert property (vec_r && vaddr_r == ivlw_pkg::VEC_EXT
    && !$past(core_if.set[0]) && !$past(wr_cis) |-> !core_if.flags[0])
    else $error("pin flag not cleared on vector");
  chk_periph_kept: assert property (vec_r && vaddr_r == ivlw_pkg::VEC_PER
    && !$past(per_if.sw_wr) |-> (per_if.flags & $past(per_if.flags)) == $past(per_if.flags))
    else $error("peripheral flag changed on vector");
  // A vector in the return cycle sets the disable bit again
  chk_return_clr: assert property (return_from_irq_instr && !wr_cs
    |=> stack_pop && (vec_r ? gid_r : !gid_r))
    else $error("return did not clear disable");
  chk_long_start: assert property (s_long_start |=> halt_r && !vec_r)
    else $error("long write did not halt");
  chk_long_hold: assert property (halt_r && !win_any |=> halt_r)
    else $error("long write ended without source");
  chk_long_end: assert property (s_long_end
    |=> !halt_r && long_end ##0 (vec_r == !$past(gid_r)))
    else $error("long write end or branch wrong");
  chk_abort_nop: assert property ((state_r == ivlw_pkg::ST_RUN) && table_write_instr
    && win_any |=> tbl_abort && !halt_r ##1 !tbl_abort)
    else $error("pending request did not abort write");
  chk_short_write: assert property ((state_r == ivlw_pkg::ST_RUN) && table_write_instr
    && !win_any && !vpp_s2_r |=> tbl_short && !halt_r)
    else $error("short write not flagged");
  chk_prio_onehot: assert property ($onehot0(win_sel)
    && (win_any == ((|core_pend) || per_pend)))
    else $error("priority pick not one-hot");
  chk_prio_order: assert property (core_pend[ivlw_pkg::SRC_EXT]
    |-> win_sel == 4'h1)
    else $error("pin source lost priority");
endmodule : ivlw_top

// *** test/ivlw_core_model.sv ***
// Core sequencer model: instruction ends, return stack and program counter
`timescale 1ns/1ps
module ivlw_core_model (
  input wire logic clk,              // Core clock
  input wire logic rst_n,            // Synchronous reset, active low
  input wire logic two_cyc,          // Every instruction takes two cycles
  input wire logic vec_take,         // Push return, load vector
  input wire logic [15:0] vec_addr,  // Vector to load
  input wire logic stack_pop,        // Pop stack into counter
  input wire logic exec_halt,        // Long write in progress
  output logic instr_end,            // End of instruction pulse
  output logic [15:0] pc,            // Program counter
  output logic [3:0] depth           // Stack depth
);
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [15:0] stk_r [0:15];
  logic phase_r;

  // Halted core ends nothing; slow mode holds off every other cycle
  assign instr_end = rst_n && !exec_halt && (!two_cyc || phase_r);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_r <= 1'b0;
      pc <= 16'h0100;
      depth <= 4'h0;
    end else begin
      phase_r <= two_cyc && !phase_r && !exec_halt;
      if (vec_take) begin
        stk_r[depth] <= pc;
        depth <= depth + 4'h1;
        pc <= vec_addr;
      end else if (stack_pop) begin
        pc <= stk_r[depth - 4'h1];
        depth <= depth - 4'h1;
      end
    end
  end
endmodule : ivlw_core_model

// *** test/tb_ivlw_top.sv ***
// Testbench of the interrupt vectoring and long write block
`timescale 1ns/1ps
module tb_ivlw_top;
  localparam logic [11:0] A_CS = ivlw_pkg::OFF_CORE_STATUS;
  localparam logic [11:0] A_CIS = ivlw_pkg::OFF_CORE_IRQ_STATUS;
  localparam logic [11:0] A_PRA = ivlw_pkg::OFF_PERIPH_REQ_A;
  localparam logic [11:0] A_PRB = ivlw_pkg::OFF_PERIPH_REQ_B;
  localparam logic [11:0] A_PEA = ivlw_pkg::OFF_PERIPH_EN_A;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, q;
  logic pready, pslverr, e;
  logic ext_pin = 1'b0, vpp = 1'b0, t0ov = 1'b0, t0ck = 1'b0;
  logic [14:0] pev = 15'h0000;
  logic ret = 1'b0, twr = 1'b0, two_cyc = 1'b1;
  logic instr_end, vec_take, stack_pop, exec_halt, long_end, tbl_abort, tbl_short;
  logic [15:0] vec_addr, pc, last_vec;
  logic [3:0] depth;
  int failures = 0, total_checks = 0;
  int n_vec = 0, n_end = 0, n_abt = 0, n_sht = 0, n_pop = 0;
  logic [15:0] vtab [4] = '{ivlw_pkg::VEC_EXT, ivlw_pkg::VEC_T0OV, ivlw_pkg::VEC_T0CK,
    ivlw_pkg::VEC_PER};
  logic [31:0] ctab [4] = '{32'h0000_00EF, 32'h0000_00CF, 32'h0000_008F, 32'h0000_008F};

  initial begin
    forever #4 core_clk = ~core_clk;
  end

  ivlw_top i_ivlw_top (.core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_irq_pin(ext_pin), .program_voltage_pin(vpp),
    .timer0_overflow(t0ov), .timer0_clock_pin_edge(t0ck), .periph_evt(pev),
    .instr_end(instr_end), .return_from_irq_instr(ret), .table_write_instr(twr),
    .vec_take(vec_take), .vec_addr(vec_addr), .stack_pop(stack_pop),
    .exec_halt(exec_halt), .long_end(long_end), .tbl_abort(tbl_abort),
    .tbl_short(tbl_short));

  ivlw_core_model i_ivlw_core_model (.clk(core_clk), .rst_n(rst_n), .two_cyc(two_cyc),
    .vec_take(vec_take), .vec_addr(vec_addr), .stack_pop(stack_pop),
    .exec_halt(exec_halt), .instr_end(instr_end), .pc(pc), .depth(depth));

  // One-cycle pulses are counted mid-cycle, where they are settled
  always @(negedge core_clk) begin
    if (vec_take === 1'b1) begin
      n_vec++;
      last_vec = vec_addr;
    end
    if (long_end === 1'b1) n_end++;
    if (tbl_abort === 1'b1) n_abt++;
    if (tbl_short === 1'b1) n_sht++;
    if (stack_pop === 1'b1) n_pop++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    total_checks++;
    if (s !== x) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, x, s);
    end
  endtask : chk

  task automatic stop_test;
    if (failures == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic tmo;
    failures++;
    $display("unexpected wait: expected event seen none");
    stop_test();
  endtask : tmo

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1 && k < 20) begin
      @(posedge core_clk);
      k++;
    end
    if (pready !== 1'b1)
      tmo();
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic await(ref int c, input int t);
    int k = 0;
    while (c < t && k < 60) begin
      @(negedge core_clk);
      k++;
    end
    if (c < t)
      tmo();
  endtask : await

  // Bit 0 pin, 1 timer0 overflow, 2 timer0 edge, 17:3 peripherals
  task automatic fire(input logic [17:0] m);
    @(posedge core_clk);
    ext_pin <= m[0];
    t0ov <= m[1];
    t0ck <= m[2];
    pev <= m[17:3];
    @(posedge core_clk);
    ext_pin <= 1'b0;
    t0ov <= 1'b0;
    t0ck <= 1'b0;
    pev <= 15'h0000;
    repeat (4) @(posedge core_clk);
  endtask : fire

  task automatic op(input logic tw);
    @(posedge core_clk);
    twr <= tw;
    ret <= !tw;
    @(posedge core_clk);
    twr <= 1'b0;
    ret <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : op

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    wr(12'h018, 32'h0000_0000);
    chk("unmapped error", e, 1'b1);
    rd(A_CS);
    chk("global disable", q, 32'h0000_0001);
    chk("mapped error", e, 1'b0);
    fire(18'h3_FFFF);
    rd(A_CIS);
    chk("core flags", q, 32'h0000_0070);
    rd(A_PRA);
    chk("periph flags a", q, 32'h0000_00FF);
    rd(A_PRB);
    chk("periph flags b", q, 32'h0000_007F);
    chk("vectors while disabled", n_vec, 0);
    wr(A_PEA, 32'h0000_0001);
    wr(A_CIS, 32'h0000_007F);
    wr(A_CS, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      await(n_vec, i + 1);
      chk("vector", last_vec, vtab[i]);
      rd(A_CS);
      chk("disable on entry", q, 32'h0000_0001);
      chk("core pc", pc, vtab[i]);
      rd(A_CIS);
      chk("flags after vector", q, ctab[i]);
      if (i == 3) begin
        rd(A_PRA);
        chk("periph flag kept", q, 32'h0000_00FF);
        wr(A_PRA, 32'h0000_0000);
        wr(A_PRB, 32'h0000_0000);
      end
      op(1'b0);
    end
    await(n_pop, 4);
    rd(A_CS);
    chk("disable after return", q, 32'h0000_0000);
    chk("returned pc", {depth, pc}, 20'h0_0100);
    chk("no repeat", n_vec, 4);
    two_cyc <= 1'b0;
    vpp <= 1'b1;
    wr(A_CS, 32'h0000_0001);
    wr(A_CIS, 32'h0000_0002);
    op(1'b1);
    chk("halted", exec_halt, 1'b1);
    fire(18'h0_0004);
    chk("halt held", exec_halt, 1'b1);
    rd(A_CS);
    chk("long write status", q, 32'h0000_0003);
    fire(18'h0_0002);
    chk("long end", n_end, 1);
    chk("halt over", exec_halt, 1'b0);
    chk("no vector", n_vec, 4);
    rd(A_CIS);
    chk("core flags after end", q, 32'h0000_0042);
    wr(A_CIS, 32'h0000_0008);
    wr(A_CS, 32'h0000_0000);
    op(1'b1);
    fire(18'h0_0008);
    chk("periph long end", n_end, 2);
    chk("periph vector", last_vec, ivlw_pkg::VEC_PER);
    rd(A_PRA);
    chk("periph flag after end", q, 32'h0000_0001);
    wr(A_PRA, 32'h0000_0000);
    op(1'b0);
    wr(A_CS, 32'h0000_0001);
    wr(A_CIS, 32'h0000_0002);
    fire(18'h0_0002);
    op(1'b1);
    chk("abort", n_abt, 1);
    chk("abort halt", exec_halt, 1'b0);
    rd(A_CIS);
    chk("abort flag", q, 32'h0000_0002);
    vpp <= 1'b0;
    wr(A_CIS, 32'h0000_0000);
    op(1'b1);
    chk("short write", {n_sht[30:0], exec_halt}, 32'h0000_0002);
    vpp <= 1'b1;
    wr(A_CIS, 32'h0000_0000);
    op(1'b1);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    @(negedge core_clk);
    chk("reset ends long write", exec_halt, 1'b0);
    rd(A_CS);
    chk("status after reset", q, 32'h0000_0001);
    wr(ivlw_pkg::OFF_PERIPH_EN_B, 32'h0000_007F);
    rd(ivlw_pkg::OFF_PERIPH_EN_B);
    chk("periph enable b", q, 32'h0000_007F);
    stop_test();
  end
endmodule : tb_ivlw_top
